/* uepc_defs.svh */
// Offsets, field positions and reset values of the endpoint control block.
`ifndef UEPC_DEFS_SVH
`define UEPC_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UEPC_CTRL_BASE 10'h1C0
`define UEPC_SET_BASE 10'h1F0
`define UEPC_CLR_BASE 10'h220
`define UEPC_EP_STRIDE 10'h004
`define UEPC_DESC_BASE 10'h310
`define UEPC_DESC_STRIDE 10'h010
// ----------------------------------------------------------------------------
// Endpoint control field positions
// ----------------------------------------------------------------------------
`define UEPC_B_HALT 19
`define UEPC_B_TOGGLE 18
`define UEPC_B_PAUSE 16
`define UEPC_B_HANDOVER 14
`define UEPC_B_DISCARD 13
`define UEPC_B_BUSYEN 12
`define UEPC_EVT_W 8
// Event positions inside the low byte.
`define UEPC_EV_INSENT 0
`define UEPC_EV_OUTRCVD 1
`define UEPC_EV_SETUP_UNDERRUN 2
`define UEPC_EV_REFOUT 3
`define UEPC_EV_REFIN 4
`define UEPC_EV_OVERRUN 5
`define UEPC_EV_HALT_CHECK 6
`define UEPC_EV_SHORT 7
// ----------------------------------------------------------------------------
// Descriptor pointer layout and reset values
// ----------------------------------------------------------------------------
`define UEPC_DESC_LSB 4
`define UEPC_DESC_W 28
`define UEPC_EVT_RESET 8'h00
`define UEPC_DESC_RESET 28'h0000000
`define UEPC_BUSY_FULL 2'h2
`endif

/* uepc_pkg.sv */
// Types shared by the endpoint control block.
package uepc_pkg;
    // Bus data word.
    typedef logic [31:0] uepc_word_t;
    // Register bus address.
    typedef logic [9:0] uepc_addr_t;
    // Progress of one bank discard procedure.
    typedef enum logic {UEPC_KILL_IDLE, UEPC_KILL_WAIT} uepc_kill_t;
endpackage

/* uepc_ctrl.sv */
// Per-endpoint control bits, set/clear aliases and DMA next-descriptor pointers.
//
// Behaviour
// - Set alias requests STALL; new SETUP or clear alias withdraws it.
// - Set alias forces DATA0 on next packet; bit clears at once.
// - With pause bit set, any endpoint event stops new DMA bank requests.
// - Ping-pong bank event lets current DMA finish, new bank not requested.
// - Non-bank events such as refused IN/OUT cancel the DMA request at once.
// - On control endpoints bank handover reads zero; software never uses it.
// - IN: handover sets when bank frees; clearing sends bank, moves on.
// - OUT: handover sets when bank fills; clearing frees bank, moves on.
// - Set alias starts discard of last written IN bank; hardware clears.
// - Discard end decrements busy count; sent instead also flags IN sent.
// - With two busy banks, first is sent and last discarded, no race.
// - Busy-count interrupt enable set and cleared by its alias bits.
// - Eight event enables set and cleared by aliases, each gates its event.
// - Clear alias per endpoint, stride four, ones clear, zeros ignored.
// - Set alias per endpoint, stride four, ones set, zeros ignored.
// - Per channel next-descriptor pointer, bits 31..4, stride 0x10, reset zero.
// - On isochronous endpoints shared positions mean underrun and check fail.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "uepc_defs.svh"

module uepc_ctrl #(
    parameter int NUM_EP = 7,
    parameter int NUM_DMA = 6
) (
    input wire logic clk_sys, // System clock, 25 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire uepc_pkg::uepc_addr_t addr, // Register byte address.
    input wire uepc_pkg::uepc_word_t wrData, // Write data.
    input wire logic wrStb, // Write strobe.
    input wire logic rdStb, // Read strobe.
    output uepc_pkg::uepc_word_t rdData, // Read data, cycle after the read strobe.
    input wire logic [NUM_EP-1:0] epIsControl, // Endpoint is a control endpoint.
    input wire logic [NUM_EP-1:0] setupRcvd, // New SETUP packet received, pulse.
    input wire logic [NUM_EP-1:0] bankReady, // IN bank freed or OUT bank filled, pulse.
    input wire logic [NUM_EP*8-1:0] evtFlags, // Endpoint event flags, levels.
    input wire logic [NUM_EP-1:0] busyEvt, // Busy-bank-count event, level.
    input wire logic [NUM_EP*2-1:0] busyBankCount, // Busy banks per endpoint.
    input wire logic [NUM_EP-1:0] killDone, // Discard procedure finished, pulse.
    input wire logic [NUM_EP-1:0] killSent, // Bank went out instead, with killDone.
    input wire logic [NUM_DMA-1:0] descLoad, // Descriptor loading writes pointer.
    input wire logic [NUM_DMA*28-1:0] descAddr, // Loaded pointer bits 31..4.
    output logic [NUM_EP-1:0] haltRequest, // Answer tokens with STALL.
    output logic [NUM_EP-1:0] toggleRestart, // Force DATA0, one-cycle pulse.
    output logic [NUM_EP-1:0] bankRelease, // Send or free bank and advance, pulse.
    output logic [NUM_EP-1:0] discardRequest, // Discard last written IN bank.
    output logic [NUM_EP-1:0] busyDecrement, // Drop busy count by one, pulse.
    output logic [NUM_EP-1:0] inSentSet, // Raise the IN sent flag, pulse.
    output logic [NUM_EP-1:0] dmaNoNewReq, // Do not request the next bank.
    output logic [NUM_EP-1:0] dmaPauseNow, // Pause the running DMA transfer.
    output logic [NUM_EP-1:0] epIrq, // Endpoint interrupt, enabled events.
    output logic [NUM_DMA*28-1:0] descPointer // Next-descriptor pointers.
);
    import uepc_pkg::*;

    // ------------------------------------------------------------------------
    // Shared wires
    // ------------------------------------------------------------------------
    // Per endpoint read words and hits, merged into one read value below.
    logic [NUM_EP-1:0] ctrlHit;
    uepc_word_t ctrlWord [NUM_EP];
    logic [NUM_DMA-1:0] descHit;
    uepc_word_t descWord [NUM_DMA];
    uepc_word_t next_rdData;

    // Events tied to a new bank packet; the rest are non-bank events.
    localparam logic [7:0] BANK_EVT_MASK = (8'h01 << `UEPC_EV_INSENT) | (8'h01 << `UEPC_EV_OUTRCVD);

    // ------------------------------------------------------------------------
    // Endpoint control slices
    // ------------------------------------------------------------------------
    for (genvar n = 0; n < NUM_EP; n++) begin : gEp
        localparam uepc_addr_t CTRL_A = uepc_addr_t'(`UEPC_CTRL_BASE + n * `UEPC_EP_STRIDE);
        localparam uepc_addr_t SET_A = uepc_addr_t'(`UEPC_SET_BASE + n * `UEPC_EP_STRIDE);
        localparam uepc_addr_t CLR_A = uepc_addr_t'(`UEPC_CLR_BASE + n * `UEPC_EP_STRIDE);

        logic setWr;
        logic clrWr;
        logic [31:0] setBits;
        logic [31:0] clrBits;
        logic [7:0] flags;
        logic [7:0] evtEn;
        logic [7:0] next_evtEn;
        logic pauseOnEvt;
        logic busyIrqEn;
        logic handover;
        logic bankAdvance;
        uepc_kill_t killState;
        logic anyEvt;
        logic otherEvt;
        logic [1:0] busyNow;

        // Alias decode: ones in the written word select the bits to act on.
        assign setWr = wrStb && (addr == SET_A);
        assign clrWr = wrStb && (addr == CLR_A);
        assign setBits = setWr ? wrData : 32'h00000000;
        assign clrBits = clrWr ? wrData : 32'h00000000;
        assign flags = evtFlags[n*8 +: 8];
        assign busyNow = busyBankCount[n*2 +: 2];

        // A set write wins over a clear of the same bit; both cannot coincide anyway.
        assign next_evtEn = (evtEn & ~clrBits[7:0]) | setBits[7:0];

        // Bank handover is only meaningful for IN and OUT data endpoints.
        assign bankAdvance = clrBits[`UEPC_B_HANDOVER] && handover && !epIsControl[n];

        // Shared positions carry underrun or check-fail on isochronous endpoints;
        // the core chooses which meaning feeds each flag, gating is the same.
        assign anyEvt = |flags;
        assign otherEvt = |(flags & ~BANK_EVT_MASK);

        // Event enables, busy interrupt enable and DMA pause enable.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                evtEn <= `UEPC_EVT_RESET;
                busyIrqEn <= 1'b0;
                pauseOnEvt <= 1'b0;
            end else begin
                evtEn <= next_evtEn;
                busyIrqEn <= setBits[`UEPC_B_BUSYEN] | (busyIrqEn & ~clrBits[`UEPC_B_BUSYEN]);
                pauseOnEvt <= setBits[`UEPC_B_PAUSE] | (pauseOnEvt & ~clrBits[`UEPC_B_PAUSE]);
            end
        end

        // Stall request: withdrawn by a new SETUP or by the clear alias.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                haltRequest[n] <= 1'b0;
            end else if (setBits[`UEPC_B_HALT]) begin
                haltRequest[n] <= 1'b1;
            end else if (setupRcvd[n] || clrBits[`UEPC_B_HALT]) begin
                haltRequest[n] <= 1'b0;
            end
        end

        // Toggle restart is a pulse, so the stored bit is never seen set.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                toggleRestart[n] <= 1'b0;
            end else begin
                toggleRestart[n] <= setBits[`UEPC_B_TOGGLE];
            end
        end

        // Bank handover: a freed or filled bank sets it, the clear alias hands
        // the bank back; a new bank in the same cycle wins over the clear.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                handover <= 1'b0;
                bankRelease[n] <= 1'b0;
            end else begin
                bankRelease[n] <= bankAdvance;
                if (epIsControl[n]) begin
                    handover <= 1'b0;
                end else if (bankReady[n]) begin
                    handover <= 1'b1;
                end else if (bankAdvance) begin
                    handover <= 1'b0;
                end
            end
        end

        // Discard procedure: request stands until the core reports the end.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                killState <= UEPC_KILL_IDLE;
                busyDecrement[n] <= 1'b0;
                inSentSet[n] <= 1'b0;
            end else begin
                busyDecrement[n] <= 1'b0;
                inSentSet[n] <= 1'b0;
                case (killState)
                    UEPC_KILL_IDLE: begin
                        if (setBits[`UEPC_B_DISCARD]) begin
                            killState <= UEPC_KILL_WAIT;
                        end
                    end
                    UEPC_KILL_WAIT: begin
                        if (killDone[n]) begin
                            killState <= UEPC_KILL_IDLE;
                            busyDecrement[n] <= 1'b1;
                            // With two banks busy the first goes out normally and
                            // the last one is discarded, so no sent flag here.
                            inSentSet[n] <= killSent[n] && (busyNow < `UEPC_BUSY_FULL);
                        end
                    end
                    default: begin
                        killState <= UEPC_KILL_IDLE;
                    end
                endcase
            end
        end

        // Discard request output follows the procedure state.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                discardRequest[n] <= 1'b0;
            end else begin
                discardRequest[n] <= (killState == UEPC_KILL_WAIT && !killDone[n])
                    || (killState == UEPC_KILL_IDLE && setBits[`UEPC_B_DISCARD]);
            end
        end

        // DMA gating ignores the interrupt enables on purpose: a masked event
        // must still stop data from landing in a buffer.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                dmaNoNewReq[n] <= 1'b0;
                dmaPauseNow[n] <= 1'b0;
            end else begin
                dmaNoNewReq[n] <= pauseOnEvt && anyEvt;
                dmaPauseNow[n] <= pauseOnEvt && otherEvt;
            end
        end

        // Endpoint interrupt: each enable gates its own event.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                epIrq[n] <= 1'b0;
            end else begin
                epIrq[n] <= (|(flags & evtEn)) || (busyEvt[n] && busyIrqEn);
            end
        end

        // Read view of the control register; handover reads zero on control
        // endpoints and toggle restart always reads zero.
        assign ctrlHit[n] = (addr == CTRL_A);
        assign ctrlWord[n] = {12'h000,
                              haltRequest[n],
                              1'b0,
                              1'b0,
                              pauseOnEvt,
                              1'b0,
                              handover && !epIsControl[n],
                              killState == UEPC_KILL_WAIT,
                              busyIrqEn,
                              4'h0,
                              evtEn};
    end

    // ------------------------------------------------------------------------
    // DMA next-descriptor pointers
    // ------------------------------------------------------------------------
    for (genvar c = 0; c < NUM_DMA; c++) begin : gDesc
        // Channel numbering starts at one, so slot c serves channel c+1.
        localparam uepc_addr_t DESC_A = uepc_addr_t'(`UEPC_DESC_BASE + c * `UEPC_DESC_STRIDE);

        logic descWr;
        logic [27:0] ptr;

        assign descWr = wrStb && (addr == DESC_A);
        assign descHit[c] = (addr == DESC_A);

        // Only bits 31..4 are stored, which keeps descriptors 16-byte aligned.
        // A software write in the same cycle as a load takes priority.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                ptr <= `UEPC_DESC_RESET;
            end else if (descWr) begin
                ptr <= wrData[31:`UEPC_DESC_LSB];
            end else if (descLoad[c]) begin
                ptr <= descAddr[c*28 +: 28];
            end
        end

        assign descWord[c] = {ptr, 4'h0};

        // Pointer output for the channel engine.
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                descPointer[c*28 +: 28] <= `UEPC_DESC_RESET;
            end else begin
                descPointer[c*28 +: 28] <= ptr;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Aliases and unmapped addresses never hit, so they read zero.
    always_comb begin
        next_rdData = 32'h00000000;
        for (int i = 0; i < NUM_EP; i++) begin
            if (ctrlHit[i]) begin
                next_rdData = next_rdData | ctrlWord[i];
            end
        end
        for (int j = 0; j < NUM_DMA; j++) begin
            if (descHit[j]) begin
                next_rdData = next_rdData | descWord[j];
            end
        end
    end

    // Read data stands for exactly one cycle after the strobe.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 32'h00000000;
        end else if (rdStb) begin
            rdData <= next_rdData;
        end else begin
            rdData <= 32'h00000000;
        end
    end
endmodule

/* uepc_ctrl_checker.sv */
// Port-level assertions for the endpoint control block.
`timescale 1ns/10ps
`include "uepc_defs.svh"
module uepc_ctrl_checker #(
    parameter int NUM_EP = 7,
    parameter int NUM_DMA = 6
) (
    input wire logic clk_sys, // Clock.
    input wire logic reset_n, // Reset, active low.
    input wire uepc_pkg::uepc_addr_t addr, // Address.
    input wire uepc_pkg::uepc_word_t wrData, // Write data.
    input wire logic wrStb, // Write strobe.
    input wire logic rdStb, // Read strobe.
    input wire uepc_pkg::uepc_word_t rdData, // Read data.
    input wire logic [NUM_EP-1:0] epIsControl, // Control type.
    input wire logic [NUM_EP-1:0] setupRcvd, // SETUP seen.
    input wire logic [NUM_EP*8-1:0] evtFlags, // Event flags.
    input wire logic [NUM_EP-1:0] busyEvt, // Busy event.
    input wire logic [NUM_EP*2-1:0] busyBankCount, // Busy banks.
    input wire logic [NUM_EP-1:0] killDone, // Discard done.
    input wire logic [NUM_EP-1:0] killSent, // Sent instead.
    input wire logic [NUM_EP-1:0] haltRequest, // STALL request.
    input wire logic [NUM_EP-1:0] toggleRestart, // DATA0 pulse.
    input wire logic [NUM_EP-1:0] bankRelease, // Bank release.
    input wire logic [NUM_EP-1:0] discardRequest, // Discard pending.
    input wire logic [NUM_EP-1:0] busyDecrement, // Count drop.
    input wire logic [NUM_EP-1:0] inSentSet, // IN sent flag.
    input wire logic [NUM_EP-1:0] dmaNoNewReq, // No new request.
    input wire logic [NUM_EP-1:0] dmaPauseNow, // Pause.
    input wire logic [NUM_EP-1:0] epIrq // Interrupt.
);
    import uepc_pkg::*;
    // ------------------------------------------------------------------------
    // Decodes for endpoint zero, the one the bench exercises in full
    // ------------------------------------------------------------------------
    wire setEp0 = wrStb && addr == `UEPC_SET_BASE;
    wire relEp0 = wrStb && addr == `UEPC_CLR_BASE && wrData[14];
    wire rdAlias = rdStb && (addr == `UEPC_SET_BASE || addr == `UEPC_CLR_BASE);
    wire anyEvt0 = |evtFlags[7:0] || busyEvt[0];
    wire hardEvt0 = |evtFlags[7:2];
    wire anyFlag0 = |evtFlags[7:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // A latency of one or two cycles is allowed, since the write lands in state first.
    AST_HALT_SET: assert property (setEp0 && wrData[19] |-> ##[1:2] haltRequest[0])
        else $error("halt request not raised by set alias");
    AST_HALT_DROP: assert property (haltRequest[0] && setupRcvd[0] && !setEp0 ##1 !setEp0 |-> ##[0:1] !haltRequest[0])
        else $error("halt request survived a SETUP");
    AST_TOGGLE: assert property (setEp0 && wrData[18] |-> ##[1:2] toggleRestart[0] ##1 !toggleRestart[0])
        else $error("toggle restart is not a single pulse");
    AST_PAUSE: assert property (dmaPauseNow[0] |-> dmaNoNewReq[0] && $past(hardEvt0))
        else $error("pause without a non-bank event");
    AST_NO_NEW: assert property (dmaNoNewReq[0] |-> $past(anyFlag0))
        else $error("new bank request blocked without an event");
    AST_CTRL_EP: assert property (epIsControl[1] && $past(epIsControl[1]) |-> !bankRelease[1])
        else $error("bank release on a control endpoint");
    AST_RELEASE: assert property (bankRelease[0] |-> $past(relEp0) || $past(relEp0, 2))
        else $error("bank release without a clear of handover");
    AST_KILL_END: assert property (discardRequest[0] && killDone[0] |=> !discardRequest[0] && busyDecrement[0])
        else $error("discard end did not drop the count");
    AST_KILL_SENT: assert property (discardRequest[0] && killDone[0] && killSent[0] |=>
        inSentSet[0] == ($past(busyBankCount[1:0]) != `UEPC_BUSY_FULL))
        else $error("IN sent flag wrong after discard");
    AST_IRQ: assert property (epIrq[0] |-> $past(anyEvt0))
        else $error("interrupt without an event");
    AST_ALIAS_READ: assert property (rdAlias |=> rdData == '0)
        else $error("alias register read nonzero");
    // Main scenarios that the bench is meant to reach.
    cover property (discardRequest[0] && killDone[0] && killSent[0]);
    cover property (dmaPauseNow[0]);
    cover property (bankRelease[0]);
endmodule
bind uepc_ctrl uepc_ctrl_checker #(.NUM_EP(NUM_EP), .NUM_DMA(NUM_DMA)) uepc_ctrl_checker_i (.clk_sys, .reset_n,
    .addr, .wrData, .wrStb, .rdStb, .rdData, .epIsControl, .setupRcvd, .evtFlags, .busyEvt, .busyBankCount,
    .killDone, .killSent, .haltRequest, .toggleRestart, .bankRelease, .discardRequest, .busyDecrement,
    .inSentSet, .dmaNoNewReq, .dmaPauseNow, .epIrq);

/* uepc_core_model.sv */
// Behavioural model of the USB core that feeds the block's link-side inputs.
`timescale 1ns/10ps
module uepc_core_model #(
    parameter int NUM_EP = 7,
    parameter int NUM_DMA = 6
) (
    input wire logic clk_sys, // System clock.
    input wire logic [NUM_EP-1:0] discardRequest, // Discard pending.
    output logic [NUM_EP-1:0] setupRcvd, // SETUP pulse.
    output logic [NUM_EP-1:0] bankReady, // Bank pulse.
    output logic [NUM_EP*8-1:0] evtFlags, // Event levels.
    output logic [NUM_EP-1:0] busyEvt, // Busy event level.
    output logic [NUM_EP*2-1:0] busyBankCount, // Busy banks.
    output logic [NUM_EP-1:0] killDone, // Discard finished.
    output logic [NUM_EP-1:0] killSent, // Bank sent instead.
    output logic [NUM_DMA-1:0] descLoad, // Descriptor load.
    output logic [NUM_DMA*28-1:0] descAddr // Loaded pointer.
);
    // Everything idles low until the bench asks for traffic.
    initial begin
        {setupRcvd, bankReady, evtFlags, busyEvt} = '0;
        {busyBankCount, killDone, killSent, descLoad, descAddr} = '0;
    end
    // One-cycle strobe: kind 0 is a SETUP, 1 a bank event, 2 and above a descriptor load.
    task automatic pulse(input int kind, input int idx, input logic [27:0] ptr);
        @(posedge clk_sys);
        descAddr[idx*28 +: 28] <= ptr;
        setupRcvd[idx] <= kind == 0;
        bankReady[idx] <= kind == 1;
        descLoad[idx] <= kind > 1;
        @(posedge clk_sys);
        {setupRcvd, bankReady, descLoad} <= '0;
    endtask
    // Event levels are held until the bench sets new ones with the next call.
    task automatic events(input int ep, input logic [7:0] flags, input logic busy);
        @(posedge clk_sys);
        evtFlags[ep*8 +: 8] <= flags;
        busyEvt[ep] <= busy;
    endtask
    // A discard completes once pending, or after 20 cycles of waiting; with two banks killSent stays low, as the first goes out normally.
    task automatic killFinish(input int ep, input logic sent, input logic [1:0] count);
        for (int n = 0; n < 20 && discardRequest[ep] !== 1'b1; n++) @(posedge clk_sys);
        @(posedge clk_sys);
        busyBankCount[ep*2 +: 2] <= count;
        killDone[ep] <= 1'b1;
        killSent[ep] <= sent && count != 2'h2;
        @(posedge clk_sys);
        {killDone, killSent} <= '0;
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the endpoint control block.
`timescale 1ns/10ps
`include "uepc_defs.svh"
module testbench;
    import uepc_pkg::*;
    localparam uepc_addr_t ctrlA = `UEPC_CTRL_BASE;
    localparam uepc_addr_t setA = `UEPC_SET_BASE;
    localparam uepc_addr_t clrA = `UEPC_CLR_BASE;
    localparam uepc_addr_t descA = `UEPC_DESC_BASE;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    uepc_addr_t addr = '0;
    uepc_word_t wrData = '0;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    uepc_word_t rdData;
    logic [6:0] epIsControl = 7'h02;
    logic [6:0] setupRcvd, bankReady, busyEvt, killDone, killSent, haltRequest, toggleRestart, bankRelease;
    logic [6:0] discardRequest, busyDecrement, inSentSet, dmaNoNewReq, dmaPauseNow, epIrq;
    logic [55:0] evtFlags;
    logic [13:0] busyBankCount;
    logic [5:0] descLoad;
    logic [167:0] descAddr, descPointer;
    logic [31:0] togCnt = '0, relCnt = '0, sentCnt = '0, decCnt = '0;
    int fail_count = 0;
    int checks = 0;
    uepc_ctrl uepc_ctrl_i (.*);
    uepc_core_model uepc_core_model_i (.*);
    always #20 clk_sys = ~clk_sys;
    // Pulse counters on endpoint zero; a stuck or doubled pulse shows up in the totals.
    always @(posedge clk_sys) if (reset_n) begin
        togCnt <= togCnt + toggleRestart[0];
        relCnt <= relCnt + bankRelease[0];
        sentCnt <= sentCnt + inSentSet[0];
        decCnt <= decCnt + busyDecrement[0];
    end
    // ------------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------------
    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input uepc_addr_t a, input uepc_word_t d);
        @(posedge clk_sys);
        {wrStb, addr, wrData} <= {1'b1, a, d};
        @(posedge clk_sys);
        wrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic chk(input string name, input uepc_addr_t a, input uepc_word_t exp);
        @(posedge clk_sys);
        {rdStb, addr} <= {1'b1, a};
        @(posedge clk_sys);
        rdStb <= 1'b0;
        #1 cmp(name, exp, rdData);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        conclude;
    end
    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        chk("ctrl", ctrlA, '0);
        chk("desc1", descA, '0);
        chk("setRead", setA, '0);
        chk("clrRead", clrA, '0);
        chk("hole", 10'h3FC, '0);
        $display("test reset done");
        wr(setA, 32'h00080000);
        chk("ctrlHalt", ctrlA, 32'h00080000);
        uepc_core_model_i.pulse(0, 0, '0);
        tick(2);
        cmp("haltSetup", 0, haltRequest[0]);
        wr(setA, 32'h00080000);
        wr(clrA, '0);
        tick(2);
        cmp("haltZero", 1, haltRequest[0]);
        wr(clrA, 32'h00080000);
        tick(2);
        cmp("haltClr", 0, haltRequest[0]);
        wr(setA, 32'h00040000);
        chk("ctrlToggle", ctrlA, '0);
        cmp("togCnt", 1, togCnt);
        $display("test halt done");
        wr(setA, 32'h000010FF);
        chk("ctrlEn", ctrlA, 32'h000010FF);
        for (int k = 0; k < 9; k++) begin
            uepc_core_model_i.events(0, k < 8 ? 8'h01 << k : 8'h00, k == 8);
            tick(2);
            cmp("irqOn", 1, epIrq[0]);
            wr(clrA, k < 8 ? 32'h1 << k : 32'h00001000);
            tick(2);
            cmp("irqOff", 0, epIrq[0]);
        end
        uepc_core_model_i.events(0, 8'h00, 1'b0);
        $display("test enables done");
        wr(setA, 32'h00010000);
        uepc_core_model_i.events(0, 8'h10, 1'b0);
        tick(2);
        cmp("pauseNak", 1, dmaPauseNow[0]);
        cmp("noNewNak", 1, dmaNoNewReq[0]);
        uepc_core_model_i.events(0, 8'h02, 1'b0);
        tick(2);
        cmp("pauseBank", 0, dmaPauseNow[0]);
        cmp("noNewBank", 1, dmaNoNewReq[0]);
        wr(clrA, 32'h00010000);
        tick(2);
        cmp("resume", 0, dmaNoNewReq[0]);
        uepc_core_model_i.events(0, 8'h00, 1'b0);
        $display("test pause done");
        uepc_core_model_i.pulse(1, 0, '0);
        chk("handSet", ctrlA, 32'h00004000);
        wr(clrA, 32'h00004000);
        chk("handClr", ctrlA, '0);
        cmp("relCnt", 1, relCnt);
        uepc_core_model_i.pulse(1, 1, '0);
        wr(clrA + 10'h004, 32'h00004000);
        chk("handCtrl", ctrlA + 10'h004, '0);
        $display("test handover done");
        wr(setA, 32'h00002000);
        chk("discardSet", ctrlA, 32'h00002000);
        uepc_core_model_i.killFinish(0, 1'b1, 2'h1);
        tick(2);
        chk("discardClr", ctrlA, '0);
        cmp("sentCnt", 1, sentCnt);
        cmp("decCnt", 1, decCnt);
        wr(setA, 32'h00002000);
        uepc_core_model_i.killFinish(0, 1'b0, 2'h2);
        tick(2);
        cmp("sentTwo", 1, sentCnt);
        cmp("decTwo", 2, decCnt);
        $display("test discard done");
        wr(descA + 10'h010, 32'hABCDEF5F);
        chk("desc2", descA + 10'h010, 32'hABCDEF50);
        cmp("descPort", 28'hABCDEF5, descPointer[55:28]);
        uepc_core_model_i.pulse(2, 0, 28'h1234567);
        chk("descLoad", descA, 32'h12345670);
        $display("test descriptor done");
        conclude;
    end
endmodule
